// ### pm_power_ctrl.sv
// Power management controller with AXI4-Lite registers and clock enable gating
//
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "pm_defines.svh"
module pm_power_ctrl
	import pm_pkg::*;
#(
	parameter int PDX_SETTLE = `PDX_SETTLE_CYC
) (
	input  wire logic              i_clk_sys,
	input  wire logic              i_rstn,
	input  wire logic [`ADDR_W-1:0] i_awaddr,
	input  wire logic              i_awvalid,
	output logic                   o_awready,
	input  wire logic [31:0]       i_wdata,
	input  wire logic [3:0]        i_wstrb,
	input  wire logic              i_wvalid,
	output logic                   o_wready,
	output logic [1:0]             o_bresp,
	output logic                   o_bvalid,
	input  wire logic              i_bready,
	input  wire logic [`ADDR_W-1:0] i_araddr,
	input  wire logic              i_arvalid,
	output logic                   o_arready,
	output logic [31:0]            o_rdata,
	output logic [1:0]             o_rresp,
	output logic                   o_rvalid,
	input  wire logic              i_rready,
	input  wire logic              i_irq_unmasked,
	input  wire logic              i_nmi,
	input  wire logic              i_instr_done,
	input  wire logic [15:0]       i_core_ad,
	output logic [15:0]            o_muxed_address_data_bus,
	input  wire logic              i_powerdown_exit_timing_pin,
	output logic                   o_powerdown_exit_timing_pin,
	output logic                   o_powerdown_exit_timing_pin_oe,
	output logic                   o_half_rate_clock_output,
	output logic                   o_exec_clk_en,
	output logic                   o_bus_clk_en,
	output logic                   o_periph_clk_en,
	output logic                   o_osc_en,
	output logic                   o_retain
);

	typedef struct packed {
		pm_mode_e               mode;
		logic                   ps_en;
		logic [`PS_DIV_W-1:0]   ps_div;
		logic                   req_idle;
		logic                   req_pd;
		logic                   exec_en;
		logic                   periph_en;
		logic                   osc_en;
		logic                   half_clk;
		logic                   retain;
		logic [15:0]            ad;
		logic                   have_aw;
		logic [`ADDR_W-1:0]     aw;
		logic                   have_w;
		logic [31:0]            wd;
		logic [3:0]             ws;
		logic                   awready;
		logic                   wready;
		logic                   bvalid;
		logic [1:0]             bresp;
		logic                   arready;
		logic                   rvalid;
		logic [31:0]            rdata;
		logic [1:0]             rresp;
	} pm_state_s;

	localparam pm_state_s RST_STATE = '{
		mode: ST_RUN, ps_en: 1'b0, ps_div: `PS_DIV_RST,
		exec_en: 1'b1, periph_en: 1'b1, osc_en: 1'b1,
		awready: 1'b1, wready: 1'b1, arready: 1'b1,
		default: '0
	};

	pm_state_s s_r;
	pm_state_s s_nxt;
	logic      wake;

	pm_ctl_if #(.SEL_W(`PS_DIV_W)) ctl ();

	if (PDX_SETTLE < 1) begin : g_chk
		$error("pm_power_ctrl: PDX_SETTLE must be at least 1");
	end

	// Address decode shared by reads and writes
	function automatic reg_sel_e decode(input logic [`ADDR_W-1:0] a);
		reg_sel_e r;
		case (a)
			`ADDR_PWR_SAVE: r = REG_SAVE;
			`ADDR_PWR_CTRL: r = REG_CTRL;
			`ADDR_PWR_STAT: r = REG_STAT;
			default:        r = REG_NONE;
		endcase
		return r;
	endfunction

	// Read data for a decoded register
	function automatic logic [31:0] read_word(input reg_sel_e sel, input pm_state_s s);
		logic [31:0] d;
		d = '0;
		case (sel)
			REG_SAVE: begin
				d[`PS_EN_BIT] = s.ps_en;
				d[`PS_DIV_LSB +: `PS_DIV_W] = s.ps_div;
			end
			REG_CTRL: begin
				d[`PC_IDLE_BIT] = s.req_idle;
				d[`PC_PD_BIT] = s.req_pd;
			end
			REG_STAT: begin
				d[`ST_MODE_LSB +: 2] = s.mode;
				d[`PS_EN_BIT] = s.ps_en;
				d[0] = s.retain;
			end
			default: d = '0;
		endcase
		return d;
	endfunction

	// Wake sources; reset wakes through the asynchronous reset itself
	assign wake = i_irq_unmasked | i_nmi;

	// Next state: bus slave, register effects, mode sequencing, clock gating
	always_comb begin
		s_nxt = s_r;
		s_nxt.half_clk = ~s_r.half_clk;

		// Write address and data taken in either order
		if (i_awvalid && s_r.awready) begin
			s_nxt.have_aw = 1'b1;
			s_nxt.aw = i_awaddr;
			s_nxt.awready = 1'b0;
		end
		if (i_wvalid && s_r.wready) begin
			s_nxt.have_w = 1'b1;
			s_nxt.wd = i_wdata;
			s_nxt.ws = i_wstrb;
			s_nxt.wready = 1'b0;
		end
		if (s_r.bvalid && i_bready) begin
			s_nxt.bvalid = 1'b0;
			s_nxt.awready = 1'b1;
			s_nxt.wready = 1'b1;
		end

		// Perform the write once both halves are held
		if (s_r.have_aw && s_r.have_w && !s_r.bvalid) begin
			s_nxt.have_aw = 1'b0;
			s_nxt.have_w = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = `RESP_OKAY;
			case (decode(s_r.aw))
				REG_SAVE: begin
					if (s_r.ws[0]) begin
						s_nxt.ps_div = s_r.wd[`PS_DIV_LSB +: `PS_DIV_W];
					end
					if (s_r.ws[1]) begin
						s_nxt.ps_en = s_r.wd[`PS_EN_BIT];
					end
				end
				REG_CTRL: begin
					if (s_r.ws[0] && s_r.wd[`PC_IDLE_BIT]) begin
						s_nxt.req_idle = 1'b1;
					end
					if (s_r.ws[0] && s_r.wd[`PC_PD_BIT]) begin
						s_nxt.req_pd = 1'b1;
					end
				end
				REG_STAT: s_nxt.bresp = `RESP_OKAY;
				default:  s_nxt.bresp = `RESP_SLVERR;
			endcase
		end

		// Read channel: one answer per request
		if (i_arvalid && s_r.arready) begin
			s_nxt.arready = 1'b0;
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata = read_word(decode(i_araddr), s_r);
			s_nxt.rresp = (decode(i_araddr) == REG_NONE) ? `RESP_SLVERR : `RESP_OKAY;
		end
		if (s_r.rvalid && i_rready) begin
			s_nxt.rvalid = 1'b0;
			s_nxt.arready = 1'b1;
		end

		// Interrupt ends power save, winning over a same-cycle software set
		if (wake) begin
			s_nxt.ps_en = 1'b0;
		end

		// Mode sequencing; powerdown request has priority over idle
		case (s_r.mode)
			ST_RUN: begin
				if ((s_r.req_pd || s_r.req_idle) && i_instr_done) begin
					s_nxt.mode = s_r.req_pd ? ST_PD : ST_IDLE;
					// Consume the pending requests; a same-cycle new request survives only if that kind was not already pending
					s_nxt.req_pd = s_nxt.req_pd && !s_r.req_pd;
					s_nxt.req_idle = s_nxt.req_idle && !s_r.req_idle;
				end
			end
			ST_IDLE: begin
				if (wake) begin
					s_nxt.mode = ST_RUN;
				end
			end
			ST_PD: begin
				if (wake) begin
					s_nxt.mode = ST_PD_EXIT;
				end
			end
			ST_PD_EXIT: begin
				if (ctl.pd_done) begin
					s_nxt.mode = ST_RUN;
				end
			end
			default: s_nxt.mode = ST_RUN;
		endcase

		// Clock enables follow the next mode
		s_nxt.exec_en = (s_nxt.mode == ST_RUN) &&
			(!s_r.ps_en || ctl.div_tick);
		s_nxt.periph_en = (s_nxt.mode == ST_RUN) || (s_nxt.mode == ST_IDLE);
		s_nxt.osc_en = (s_nxt.mode != ST_PD);
		s_nxt.retain = (s_nxt.mode == ST_PD) || (s_nxt.mode == ST_PD_EXIT);

		// Address/data pins pass the core value except while powered down
		if (!s_nxt.retain) begin
			s_nxt.ad = i_core_ad;
		end else begin
			s_nxt.ad = s_r.ad;
		end
	end

	// State register; reset restores full-rate running
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			s_r <= RST_STATE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Links to the divider and the exit timer
	assign ctl.div_sel = s_r.ps_div;
	assign ctl.div_run = s_r.ps_en;
	assign ctl.pd_hold = (s_r.mode == ST_PD);
	assign ctl.pd_exit = (s_r.mode == ST_PD_EXIT);
	assign ctl.pin_in  = i_powerdown_exit_timing_pin;

	pm_clk_div #(
		.SEL_W (`PS_DIV_W)
	) u_div (
		.i_clk_sys (i_clk_sys),
		.i_rstn    (i_rstn),
		.dv        (ctl.div)
	);

	pm_pd_exit #(
		.SETTLE (PDX_SETTLE)
	) u_pdx (
		.i_clk_sys (i_clk_sys),
		.i_rstn    (i_rstn),
		.px        (ctl.pdx)
	);

	// Outputs straight from flip-flops, except the timing pin drive value, which is tied low
	assign o_awready = s_r.awready;
	assign o_wready  = s_r.wready;
	assign o_bvalid  = s_r.bvalid;
	assign o_bresp   = s_r.bresp;
	assign o_arready = s_r.arready;
	assign o_rvalid  = s_r.rvalid;
	assign o_rdata   = s_r.rdata;
	assign o_rresp   = s_r.rresp;
	assign o_muxed_address_data_bus = s_r.ad;
	assign o_powerdown_exit_timing_pin    = ctl.pin_out;
	assign o_powerdown_exit_timing_pin_oe = ctl.pin_oe;
	assign o_half_rate_clock_output = s_r.half_clk;
	assign o_exec_clk_en   = s_r.exec_en;
	assign o_bus_clk_en    = s_r.exec_en;
	assign o_periph_clk_en = s_r.periph_en;
	assign o_osc_en        = s_r.osc_en;
	assign o_retain        = s_r.retain;
endmodule
`default_nettype wire

// ### pm_defines.svh
// Register offsets, field positions, reset values and timing counts of the power block
`ifndef PM_DEFINES_SVH
`define PM_DEFINES_SVH

// Register indices; byte address is four times the index
`define IDX_PWR_SAVE      8'hf0
`define IDX_PWR_CTRL      8'hf2
`define IDX_PWR_STAT      8'hf4
`define ADDR_W            12
`define ADDR_PWR_SAVE     ({2'h0, `IDX_PWR_SAVE, 2'h0})
`define ADDR_PWR_CTRL     ({2'h0, `IDX_PWR_CTRL, 2'h0})
`define ADDR_PWR_STAT     ({2'h0, `IDX_PWR_STAT, 2'h0})

// Power save register fields
`define PS_EN_BIT         15
`define PS_DIV_LSB        0
`define PS_DIV_W          3
`define PS_DIV_RST        3'h0

// Power control register fields
`define PC_IDLE_BIT       0
`define PC_PD_BIT         1

// Status register fields
`define ST_MODE_LSB       4

// AXI responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

// Powerdown exit settle time once the timing pin reads high
`define CLK_PERIOD_NS     40
`define PDX_SETTLE_NS     200
`define PDX_SETTLE_CYC    ((`PDX_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### pm_pkg.sv
// Types shared by the power management block
package pm_pkg;

	// Operating mode of the core clocks
	typedef enum logic [1:0] {
		ST_RUN,
		ST_IDLE,
		ST_PD,
		ST_PD_EXIT
	} pm_mode_e;

	// Register decode result
	typedef enum logic [1:0] {
		REG_SAVE,
		REG_CTRL,
		REG_STAT,
		REG_NONE
	} reg_sel_e;

endpackage

// ### pm_ctl_if.sv
// Control links between the power controller and its divider and exit timer
`timescale 1ns/10ps
`default_nettype none
interface pm_ctl_if #(
	parameter int SEL_W = 3
);
	logic [SEL_W-1:0] div_sel;
	logic             div_run;
	logic             div_tick;
	logic             pd_hold;
	logic             pd_exit;
	logic             pd_done;
	logic             pin_in;
	logic             pin_out;
	logic             pin_oe;

	modport ctl (output div_sel, output div_run, output pd_hold, output pd_exit,
		output pin_in, input div_tick, input pd_done, input pin_out, input pin_oe);
	modport div (input div_sel, input div_run, output div_tick);
	modport pdx (input pd_hold, input pd_exit, input pin_in,
		output pd_done, output pin_out, output pin_oe);
endinterface
`default_nettype wire

// ### pm_clk_div.sv
// Power save divider: one-cycle enable every 2**div_sel clocks
`timescale 1ns/10ps
`default_nettype none
module pm_clk_div #(
	parameter int SEL_W = 3
) (
	input  wire logic i_clk_sys,
	input  wire logic i_rstn,
	pm_ctl_if.div     dv
);
	localparam int CNT_W = (1 << SEL_W) - 1;

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             tick;
	} div_state_s;

	div_state_s s_r;
	div_state_s s_nxt;
	logic [CNT_W-1:0] limit;

	if (SEL_W < 1 || SEL_W > 4) begin : g_chk
		$error("pm_clk_div: SEL_W must be 1 to 4");
	end

	// Terminal count for the selected divisor
	assign limit = CNT_W'((CNT_W+1)'(1) << dv.div_sel) - CNT_W'(1);

	// Count and pulse; idle at zero when power save is off
	always_comb begin
		s_nxt = s_r;
		if (!dv.div_run) begin
			s_nxt.cnt = '0;
			s_nxt.tick = 1'b0;
		end else if (s_r.cnt >= limit) begin
			s_nxt.cnt = '0;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.cnt = s_r.cnt + CNT_W'(1);
			s_nxt.tick = 1'b0;
		end
	end

	// State register
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign dv.div_tick = s_r.tick;
endmodule
`default_nettype wire

// ### pm_pd_exit.sv
// Powerdown exit timer: discharges the timing pin, then waits for it to settle high
`timescale 1ns/10ps
`default_nettype none
`include "pm_defines.svh"
module pm_pd_exit #(
	parameter int SETTLE = `PDX_SETTLE_CYC
) (
	input  wire logic i_clk_sys,
	input  wire logic i_rstn,
	pm_ctl_if.pdx     px
);
	localparam int CNT_W = $clog2(SETTLE + 1);

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             done;
		logic             oe;
	} pdx_state_s;

	pdx_state_s s_r;
	pdx_state_s s_nxt;

	if (SETTLE < 1) begin : g_chk
		$error("pm_pd_exit: SETTLE must be at least 1");
	end

	// Drive low while down, release on wake, count consecutive high samples
	always_comb begin
		s_nxt = s_r;
		s_nxt.oe = !px.pd_hold;
		if (px.pd_exit) begin
			if (!px.pin_in) begin
				s_nxt.cnt = '0;
			end else if (s_r.cnt < CNT_W'(SETTLE)) begin
				s_nxt.cnt = s_r.cnt + CNT_W'(1);
			end
			s_nxt.done = px.pin_in && (s_r.cnt >= CNT_W'(SETTLE - 1));
		end else begin
			s_nxt.cnt = '0;
			s_nxt.done = 1'b0;
		end
	end

	// State register; pin released at reset
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			s_r <= '{cnt: '0, done: 1'b0, oe: 1'b1};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign px.pd_done = s_r.done;
	assign px.pin_out = 1'b0;
	assign px.pin_oe  = s_r.oe;
endmodule
`default_nettype wire

// ### pm_power_ctrl_props.sv
// Port-level checks on clock gating, retention and powerdown exit
`timescale 1ns/10ps
`default_nettype none
module pm_power_ctrl_props (
	input wire logic        i_clk_sys,
	input wire logic        i_rstn,
	input wire logic        i_irq_unmasked,
	input wire logic        i_nmi,
	input wire logic        i_instr_done,
	input wire logic        i_powerdown_exit_timing_pin,
	input wire logic [15:0] o_muxed_address_data_bus,
	input wire logic        o_powerdown_exit_timing_pin_oe,
	input wire logic        o_half_rate_clock_output,
	input wire logic        o_exec_clk_en,
	input wire logic        o_bus_clk_en,
	input wire logic        o_periph_clk_en,
	input wire logic        o_osc_en,
	input wire logic        o_retain
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);
	// Output clock, gating, retention and exit relations
	half_rate_a: assert property ($past(i_rstn) |->
		o_half_rate_clock_output != $past(o_half_rate_clock_output))
		else $error("half rate clock did not toggle");
	all_gated_a: assert property (o_retain |->
		!o_exec_clk_en && !o_bus_clk_en && !o_periph_clk_en)
		else $error("clock enable high while retaining");
	periph_run_a: assert property (!o_periph_clk_en |-> o_retain)
		else $error("peripheral clock stopped outside powerdown");
	osc_off_a: assert property ($rose(o_retain) |-> !o_osc_en)
		else $error("oscillator left on at powerdown entry");
	entry_done_a: assert property ($fell(o_periph_clk_en) |-> $past(i_instr_done))
		else $error("powerdown entered without instruction end");
	ad_hold_a: assert property (o_retain && $past(o_retain) |->
		$stable(o_muxed_address_data_bus))
		else $error("address data bus moved while retaining");
	wake_osc_a: assert property (o_retain && !o_osc_en && (i_irq_unmasked || i_nmi) |=>
		o_osc_en) else $error("wake did not restart oscillator");
	pin_drive_a: assert property (o_retain && !o_osc_en && $past(o_retain) |->
		!o_powerdown_exit_timing_pin_oe) else $error("timing pin not driven in powerdown");
	exit_wait_a: assert property (o_retain && o_osc_en && !i_powerdown_exit_timing_pin |=>
		o_retain) else $error("powerdown left before timing pin settled");
endmodule
bind pm_power_ctrl pm_power_ctrl_props u_pm_power_ctrl_props (.*);
`default_nettype wire

// ### pm_core_model.sv
// Far side model: instruction pacing, address/data source and exit timing element
`timescale 1ns/10ps
`default_nettype none
module pm_core_model #(
	parameter int INSTR = 3,
	parameter int RC    = 4
) (
	input  wire logic        i_clk_sys,
	input  wire logic        i_rstn,
	input  wire logic        i_pin_drv,
	input  wire logic        i_pin_oe,
	output logic             o_instr_done,
	output logic [15:0]      o_core_ad,
	output logic             o_pin
);
	int ic;
	int rc;
	// Instruction end pulses and an ever changing bus value
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			ic <= 0;
			o_instr_done <= 1'b0;
			o_core_ad <= 16'h0;
		end else begin
			ic <= (ic == INSTR - 1) ? 0 : ic + 1;
			o_instr_done <= (ic == INSTR - 1);
			o_core_ad <= o_core_ad + 16'h1357;
		end
	end
	// Capacitor discharged while driven, charges through the pull-up once released
	always_ff @(posedge i_clk_sys) begin
		rc <= !i_pin_oe ? 0 : (rc < RC ? rc + 1 : rc);
	end
	assign o_pin = !i_pin_oe ? i_pin_drv : (rc >= RC);
endmodule
`default_nettype wire

// ### test_pm_power_ctrl.sv
// Register-driven bench for the power controller
`timescale 1ns/10ps
`default_nettype none
`include "pm_defines.svh"
module test_pm_power_ctrl;
	logic        clk, rstn, awvalid, wvalid, bready, arvalid, rready, irq, nmi;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [15:0] core_ad, bus, hold;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic        awready, wready, bvalid, arready, rvalid, done, pin, pin_drv, pin_oe;
	logic        half, exec_en, bus_en, periph_en, osc_en, retain;
	int          miscompares = 0, checked = 0, cyc = 0, n, c;

	pm_power_ctrl #(.PDX_SETTLE(2)) u_pm_power_ctrl (.i_clk_sys(clk), .i_rstn(rstn),
		.i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
		.i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
		.o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
		.o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
		.i_rready(rready), .i_irq_unmasked(irq), .i_nmi(nmi), .i_instr_done(done),
		.i_core_ad(core_ad), .o_muxed_address_data_bus(bus),
		.i_powerdown_exit_timing_pin(pin), .o_powerdown_exit_timing_pin(pin_drv),
		.o_powerdown_exit_timing_pin_oe(pin_oe), .o_half_rate_clock_output(half),
		.o_exec_clk_en(exec_en), .o_bus_clk_en(bus_en), .o_periph_clk_en(periph_en),
		.o_osc_en(osc_en), .o_retain(retain));
	pm_core_model u_pm_core_model (.i_clk_sys(clk), .i_rstn(rstn), .i_pin_drv(pin_drv),
		.i_pin_oe(pin_oe), .o_instr_done(done), .o_core_ad(core_ad), .o_pin(pin));

	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			results();
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic results();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Register write; handshakes judged at the settled half cycle
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		bit ha, hw, hb;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge clk);
			ha = awvalid & awready;
			hw = wvalid & wready;
			hb = bvalid & bready;
			if (hb) chk("bresp", bresp, er);
			@(posedge clk);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
			if (hb) bready <= 1'b0;
		end while (!hb);
	endtask

	// Register read with data and response compare
	task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		bit ha, hr;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clk);
			ha = arvalid & arready;
			hr = rvalid & rready;
			if (hr) chk("rdata", rdata, ed);
			if (hr) chk("rresp", rresp, er);
			@(posedge clk);
			if (ha) arvalid <= 1'b0;
			if (hr) rready <= 1'b0;
		end while (!hr);
	endtask

	// Counts execution clock enables over a window
	task automatic cnt(input int len, input int exp);
		c = 0;
		repeat (len) begin
			@(negedge clk);
			c += exec_en;
		end
		chk("exec_en pulses", c, exp);
		@(posedge clk);
	endtask

	// Bounded wait for execution enable or retain to reach a level
	task automatic wt(input bit sel, input logic v);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while ((sel ? retain : exec_en) !== v && n < 60);
		chk("wait bound", n < 60, 1);
		@(posedge clk);
	endtask

	// Main sequence
	initial begin
		{rstn, awvalid, wvalid, bready, arvalid, rready, irq, nmi} = 8'h0;
		{awaddr, araddr, wdata} = 56'h0;
		wstrb = 4'hf;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		chk("run enables", {exec_en, bus_en, periph_en, osc_en, retain}, 5'h1e);
		c = half;
		@(negedge clk);
		chk("half rate", half, !c);
		rd(`ADDR_PWR_SAVE, 32'h0, `RESP_OKAY);
		wr(`ADDR_PWR_STAT, 32'hffff, `RESP_OKAY);
		rd(`ADDR_PWR_STAT, 32'h0, `RESP_OKAY);
		wr(12'h3fc, 32'h1, `RESP_SLVERR);
		rd(12'h3fc, 32'h0, `RESP_SLVERR);
		for (int s = 0; s < 8; s++) begin
			wr(`ADDR_PWR_SAVE, 32'h8000 | s, `RESP_OKAY);
			repeat (4) @(posedge clk);
			cnt(8 << s, 8);
			if (s[0]) irq <= 1'b1;
			else nmi <= 1'b1;
			@(posedge clk);
			{irq, nmi} <= 2'h0;
			rd(`ADDR_PWR_SAVE, 32'(s), `RESP_OKAY);
			cnt(8, 8);
		end
		wr(`ADDR_PWR_CTRL, 32'h1, `RESP_OKAY);
		wt(1'b0, 1'b0);
		chk("idle enables", {bus_en, periph_en, osc_en, retain}, 4'h6);
		rd(`ADDR_PWR_STAT, 32'h10, `RESP_OKAY);
		irq <= 1'b1;
		wt(1'b0, 1'b1);
		irq <= 1'b0;
		wstrb <= 4'h1;
		wr(`ADDR_PWR_SAVE, 32'h8006, `RESP_OKAY);
		rd(`ADDR_PWR_SAVE, 32'h6, `RESP_OKAY);
		wstrb <= 4'hf;
		wr(`ADDR_PWR_SAVE, 32'h5, `RESP_OKAY);
		wr(`ADDR_PWR_CTRL, 32'h3, `RESP_OKAY);
		wt(1'b1, 1'b1);
		hold = bus;
		repeat (3) @(negedge clk);
		chk("bus hold", bus, hold);
		chk("pd enables", {exec_en, bus_en, periph_en, osc_en}, 4'h0);
		chk("pin drive", {pin_oe, pin_drv}, 2'h0);
		rd(`ADDR_PWR_STAT, 32'h21, `RESP_OKAY);
		rd(`ADDR_PWR_SAVE, 32'h5, `RESP_OKAY);
		nmi <= 1'b1;
		@(posedge clk);
		nmi <= 1'b0;
		wt(1'b1, 1'b0);
		chk("run enables", {exec_en, bus_en, periph_en, osc_en}, 4'hf);
		rd(`ADDR_PWR_CTRL, 32'h0, `RESP_OKAY);
		wr(`ADDR_PWR_CTRL, 32'h1, `RESP_OKAY);
		wt(1'b0, 1'b0);
		rstn <= 1'b0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		wt(1'b0, 1'b1);
		rd(`ADDR_PWR_STAT, 32'h0, `RESP_OKAY);
		results();
	end
endmodule
`default_nettype wire
